// File: core/eti_tx_overhead.sv
/*
 * E3 transmit overhead control and framing error insertion.
 * Assumes upstream marks overhead beats and the line may stall;
 * alarms and the manual insert input are asynchronous.
 */
// The implementer's own choice: strobed register access.
// Functional notes
// - N bit: one, HDLC, FEAC or zero.
// - A bit: auto, FEAC, zero or one.
// - N and A share one FEAC stream.
// - Generation on: overhead replaced internally.
// - Generation off: overhead passes through unchanged.
// - Overhead insertion still overwrites overhead periods.
// - AIS control forces whole output to ones.
// - Error type: bit or word, one or four.
// - Enable bit gates all framing error insertion.
// - Register bit rise inserts one error, in one frame or in four.
// - Several rises between opportunities give one.
// - Source select one uses manual input instead.
// - Auto A bit follows enabled receive alarms.
`timescale 1ns/1ps
module eti_tx_overhead (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic in_valid,
    input wire eti_pkg::eti_beat_t in_beat,
    output logic in_ready,
    input wire logic hdlc_data,
    output logic hdlc_advance,
    input wire logic feac_data,
    output logic feac_advance,
    input wire eti_pkg::eti_alarm_t rx_alarm,
    input wire logic manual_error_insert_input,
    output logic line_valid,
    output logic line_data,
    input wire logic line_ready
);

    // Register fields.
    logic [15:0] ovh_ctrl_q;
    logic [15:0] err_ctrl_q;
    logic [15:0] rai_ctrl_q;
    logic [15:0] reg_rdata_q;

    eti_pkg::eti_n_src_t n_bit_source_sel;
    eti_pkg::eti_a_src_t a_bit_source_sel;
    eti_pkg::eti_err_type_t framing_error_type_sel;
    logic frame_gen_disable;
    logic force_all_ones_tx;
    logic framing_error_insert_en;
    logic single_error_insert_trigger;
    logic insert_source_select;

    // Synchronised inputs.
    logic [4:0] async_vec;
    logic [4:0] sync_level;
    logic [4:0] sync_rise;
    eti_pkg::eti_alarm_t alarm_s;
    logic manual_rise;

    // Error engine.
    logic single_rise;
    logic trig_rise;
    logic pend_q;
    logic [2:0] left_q;
    logic err_frame_q;
    logic err_word_q;
    logic frame_take;
    logic start_now;
    logic err_now;
    logic word_now;

    // Data path.
    logic fire;
    logic buf_ready;
    logic auto_a;
    logic a_val;
    logic n_val;
    logic out_bit;
    logic hdlc_adv_q;
    logic feac_adv_q;

    function automatic logic fas_bit(input logic [3:0] idx);
        logic [3:0] pos;
        pos = 4'(eti_pkg::FAS_LEN - 1) - idx;
        fas_bit = eti_pkg::FAS_PATTERN[pos];
    endfunction : fas_bit

    function automatic logic [15:0] masked(input logic [15:0] val, input logic [15:0] msk);
        masked = val & msk;
    endfunction : masked

    assign n_bit_source_sel = eti_pkg::eti_n_src_t'(ovh_ctrl_q[eti_pkg::N_SRC_LSB +: 2]);
    assign a_bit_source_sel = eti_pkg::eti_a_src_t'(ovh_ctrl_q[eti_pkg::A_SRC_LSB +: 2]);
    assign frame_gen_disable = ovh_ctrl_q[eti_pkg::FRAME_GEN_DIS_BIT];
    assign force_all_ones_tx = ovh_ctrl_q[eti_pkg::FORCE_AIS_BIT];
    assign framing_error_type_sel =
        eti_pkg::eti_err_type_t'(err_ctrl_q[eti_pkg::ERR_TYPE_LSB +: 2]);
    assign framing_error_insert_en = err_ctrl_q[eti_pkg::ERR_EN_BIT];
    assign single_error_insert_trigger = err_ctrl_q[eti_pkg::SINGLE_TRIG_BIT];
    assign insert_source_select = err_ctrl_q[eti_pkg::SRC_SEL_BIT];

    // Register writes; reserved bits are never stored so they read as zero.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ovh_ctrl_q <= eti_pkg::TX_OVH_CTRL_RST;
            err_ctrl_q <= eti_pkg::TX_ERR_CTRL_RST;
            rai_ctrl_q <= eti_pkg::RAI_CTRL_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                eti_pkg::TX_OVH_CTRL_OFS: begin
                    ovh_ctrl_q <= masked(reg_wdata, eti_pkg::TX_OVH_CTRL_MASK);
                end
                eti_pkg::TX_ERR_CTRL_OFS: begin
                    err_ctrl_q <= masked(reg_wdata, eti_pkg::TX_ERR_CTRL_MASK);
                end
                eti_pkg::RAI_CTRL_OFS: begin
                    rai_ctrl_q <= masked(reg_wdata, eti_pkg::RAI_CTRL_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads answer in the next cycle; unmapped addresses read zero.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                eti_pkg::TX_OVH_CTRL_OFS: begin
                    reg_rdata_q <= ovh_ctrl_q;
                end
                eti_pkg::TX_ERR_CTRL_OFS: begin
                    reg_rdata_q <= err_ctrl_q;
                end
                eti_pkg::RAI_CTRL_OFS: begin
                    reg_rdata_q <= rai_ctrl_q;
                end
                eti_pkg::TX_STATUS_OFS: begin
                    reg_rdata_q <= 16'h0000;
                    reg_rdata_q[eti_pkg::STAT_PEND_BIT] <= pend_q;
                    reg_rdata_q[eti_pkg::STAT_LEFT_LSB +: 3] <= left_q;
                    reg_rdata_q[eti_pkg::STAT_ERR_FRAME_BIT] <= err_frame_q;
                    reg_rdata_q[eti_pkg::STAT_AUTO_A_BIT] <= auto_a;
                end
                default: begin
                    reg_rdata_q <= 16'h0000;
                end
            endcase
        end
    end

    // The register trigger is already in this clock;
    // only a write that raises it counts.
    assign single_rise = reg_wr && (reg_addr == eti_pkg::TX_ERR_CTRL_OFS)
        && reg_wdata[eti_pkg::SINGLE_TRIG_BIT] && !single_error_insert_trigger;

    assign async_vec = {manual_error_insert_input, rx_alarm};

    eti_sync #(
        .WIDTH(5)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(async_vec),
        .level(sync_level),
        .rise(sync_rise)
    );

    assign alarm_s = eti_pkg::eti_alarm_t'(sync_level[eti_pkg::ALARM_W-1:0]);
    assign manual_rise = sync_rise[eti_pkg::ALARM_W];

    // Each source is edge detected on its own,
    // so switching the select makes no edge.
    assign trig_rise = insert_source_select ? manual_rise : single_rise;

    // The opportunity is the first alignment bit of each accepted frame.
    assign fire = in_valid & buf_ready;
    assign frame_take = fire && in_beat.fas && (in_beat.fas_idx == 4'h0);
    assign start_now = frame_take && pend_q && framing_error_insert_en;
    assign err_now = (in_beat.fas && (in_beat.fas_idx == 4'h0))
        ? (start_now || (framing_error_insert_en && (left_q != 3'h0)))
        : err_frame_q;
    assign word_now = start_now
        ? framing_error_type_sel[0]
        : err_word_q;

    // A new edge wins over consumption in the same cycle;
    // edges before the next frame collapse into one.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pend_q <= 1'b0;
        end else if (!framing_error_insert_en) begin
            pend_q <= 1'b0;
        end else if (trig_rise) begin
            pend_q <= 1'b1;
        end else if (frame_take) begin
            pend_q <= 1'b0;
        end
    end

    // Frames still to be errored after the current one in a four-frame burst.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            left_q <= 3'h0;
        end else if (!framing_error_insert_en) begin
            left_q <= 3'h0;
        end else if (start_now) begin
            left_q <= framing_error_type_sel[1] ? eti_pkg::BURST_EXTRA_FRAMES : 3'h0;
        end else if (frame_take && (left_q != 3'h0)) begin
            left_q <= left_q - 3'h1;
        end
    end

    // The errored-frame flag covers the rest of the alignment word.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            err_frame_q <= 1'b0;
            err_word_q <= 1'b0;
        end else if (!framing_error_insert_en) begin
            err_frame_q <= 1'b0;
        end else if (frame_take) begin
            err_frame_q <= err_now;
            err_word_q <= word_now;
        end
    end

    // Remote alarm value for the automatic A bit.
    assign auto_a = (alarm_s.los && !rai_ctrl_q[eti_pkg::RAI_LOS_DIS_BIT])
        || (alarm_s.oof && !rai_ctrl_q[eti_pkg::RAI_OOF_DIS_BIT])
        || (alarm_s.ais && !rai_ctrl_q[eti_pkg::RAI_AIS_DIS_BIT])
        || (alarm_s.lof && rai_ctrl_q[eti_pkg::RAI_LOF_EN_BIT]);

    always_comb begin
        a_val = 1'b0;
        unique case (a_bit_source_sel)
            eti_pkg::A_SRC_AUTO: a_val = auto_a;
            eti_pkg::A_SRC_FEAC: a_val = feac_data;
            eti_pkg::A_SRC_ZERO: a_val = 1'b0;
            eti_pkg::A_SRC_ONE: a_val = 1'b1;
        endcase
    end

    always_comb begin
        n_val = 1'b1;
        unique case (n_bit_source_sel)
            eti_pkg::N_SRC_ONE: n_val = 1'b1;
            eti_pkg::N_SRC_HDLC: n_val = hdlc_data;
            eti_pkg::N_SRC_FEAC: n_val = feac_data;
            eti_pkg::N_SRC_ZERO: n_val = 1'b0;
        endcase
    end

    // Order: frame generation, overhead insertion, error insertion, AIS.
    always_comb begin
        out_bit = in_beat.data;
        if (!frame_gen_disable) begin
            if (in_beat.fas) begin
                out_bit = fas_bit(in_beat.fas_idx);
            end else if (in_beat.a_pos) begin
                out_bit = a_val;
            end else if (in_beat.n_pos) begin
                out_bit = n_val;
            end
        end
        if (in_beat.ovh_ins_en && (in_beat.fas || in_beat.a_pos || in_beat.n_pos)) begin
            out_bit = in_beat.ovh_ins_data;
        end
        if (in_beat.fas && err_now && (word_now || (in_beat.fas_idx == 4'h0))) begin
            out_bit = ~out_bit;
        end
        if (force_all_ones_tx) begin
            out_bit = 1'b1;
        end
    end

    // The HDLC advance follows the N beat that used the bit; the FEAC advance follows each frame's first alignment bit.
    // FEAC moves on once per frame even when both N and A carry it.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hdlc_adv_q <= 1'b0;
            feac_adv_q <= 1'b0;
        end else begin
            hdlc_adv_q <= fire && in_beat.n_pos && !frame_gen_disable
                && (n_bit_source_sel == eti_pkg::N_SRC_HDLC);
            feac_adv_q <= frame_take && !frame_gen_disable
                && ((n_bit_source_sel == eti_pkg::N_SRC_FEAC)
                || (a_bit_source_sel == eti_pkg::A_SRC_FEAC));
        end
    end

    eti_skid_buf #(
        .WIDTH(eti_pkg::BUF_WIDTH)
    ) u_buf (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(in_valid),
        .in_data(out_bit),
        .in_ready(buf_ready),
        .out_valid(line_valid),
        .out_data(line_data),
        .out_ready(line_ready)
    );

    assign in_ready = buf_ready;
    assign reg_rdata = reg_rdata_q;
    assign hdlc_advance = hdlc_adv_q;
    assign feac_advance = feac_adv_q;

endmodule : eti_tx_overhead

// File: core/eti_pkg.sv
/*
 * Constants and types of the E3 transmit overhead block.
 * Assumes a 16-bit register port and one bit per beat.
 */
package eti_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    localparam logic [7:0] TX_OVH_CTRL_OFS = 8'h18;
    localparam logic [7:0] TX_ERR_CTRL_OFS = 8'h1a;
    localparam logic [7:0] RAI_CTRL_OFS = 8'h1c;
    localparam logic [7:0] TX_STATUS_OFS = 8'h1e;

    localparam logic [15:0] TX_OVH_CTRL_RST = 16'h0000;
    localparam logic [15:0] TX_ERR_CTRL_RST = 16'h0000;
    localparam logic [15:0] RAI_CTRL_RST = 16'h0000;
    localparam logic [15:0] TX_OVH_CTRL_MASK = 16'h030f;
    localparam logic [15:0] TX_ERR_CTRL_MASK = 16'h001f;
    localparam logic [15:0] RAI_CTRL_MASK = 16'h00f0;

    localparam int unsigned N_SRC_LSB = 8;
    localparam int unsigned A_SRC_LSB = 2;
    localparam int unsigned FRAME_GEN_DIS_BIT = 1;
    localparam int unsigned FORCE_AIS_BIT = 0;

    localparam int unsigned ERR_TYPE_LSB = 3;
    localparam int unsigned ERR_EN_BIT = 2;
    localparam int unsigned SINGLE_TRIG_BIT = 1;
    localparam int unsigned SRC_SEL_BIT = 0;

    localparam int unsigned RAI_LOF_EN_BIT = 7;
    localparam int unsigned RAI_LOS_DIS_BIT = 6;
    localparam int unsigned RAI_OOF_DIS_BIT = 5;
    localparam int unsigned RAI_AIS_DIS_BIT = 4;

    localparam int unsigned STAT_PEND_BIT = 0;
    localparam int unsigned STAT_LEFT_LSB = 1;
    localparam int unsigned STAT_ERR_FRAME_BIT = 4;
    localparam int unsigned STAT_AUTO_A_BIT = 5;

    localparam int unsigned FAS_LEN = 10;
    localparam logic [9:0] FAS_PATTERN = 10'h3d0;
    localparam logic [2:0] BURST_EXTRA_FRAMES = 3'h3;

    localparam int unsigned BUF_WIDTH = 1;
    localparam int unsigned ALARM_W = 4;

    typedef enum logic [1:0] {
        N_SRC_ONE = 2'h0,
        N_SRC_HDLC = 2'h1,
        N_SRC_FEAC = 2'h2,
        N_SRC_ZERO = 2'h3
    } eti_n_src_t;

    typedef enum logic [1:0] {
        A_SRC_AUTO = 2'h0,
        A_SRC_FEAC = 2'h1,
        A_SRC_ZERO = 2'h2,
        A_SRC_ONE = 2'h3
    } eti_a_src_t;

    typedef enum logic [1:0] {
        ERR_BIT_ONE = 2'h0,
        ERR_WORD_ONE = 2'h1,
        ERR_BIT_FOUR = 2'h2,
        ERR_WORD_FOUR = 2'h3
    } eti_err_type_t;

    typedef struct packed {
        logic data;
        logic fas;
        logic [3:0] fas_idx;
        logic a_pos;
        logic n_pos;
        logic ovh_ins_en;
        logic ovh_ins_data;
    } eti_beat_t;

    typedef struct packed {
        logic los;
        logic oof;
        logic ais;
        logic lof;
    } eti_alarm_t;

endpackage : eti_pkg

// File: core/eti_sync.sv
/*
 * Two-flop synchroniser with rising-edge detect.
 * Assumes asynchronous inputs; edges come from flops two and three.
 */
`timescale 1ns/1ps
module eti_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~last_q;

endmodule : eti_sync

// File: core/eti_skid_buf.sv
/*
 * Two-entry valid/ready buffer; all outputs come from flops.
 * Assumes the drain side may stall for any time.
 */
`timescale 1ns/1ps
module eti_skid_buf #(
    parameter int unsigned WIDTH = eti_pkg::BUF_WIDTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    logic [WIDTH-1:0] mem_q [0:1];
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic in_ready_q;
    logic out_valid_q;
    logic push;
    logic pop;

    assign push = in_valid & in_ready_q;
    assign pop = out_valid_q & out_ready;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 2'h0;
            in_ready_q <= 1'b1;
            out_valid_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != 2'h2);
            out_valid_q <= (cnt_d != 2'h0);
        end
    end

    // Entry 0 is always the head; a pop shifts entry 1 down.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (pop) begin
                mem_q[0] <= mem_q[1];
            end
            if (push) begin
                if (pop) begin
                    if (cnt_q == 2'h1) begin
                        mem_q[0] <= in_data;
                    end else begin
                        mem_q[1] <= in_data;
                    end
                end else if (cnt_q == 2'h0) begin
                    mem_q[0] <= in_data;
                end else begin
                    mem_q[1] <= in_data;
                end
            end
        end
    end

    assign in_ready = in_ready_q;
    assign out_valid = out_valid_q;
    assign out_data = mem_q[0];

endmodule : eti_skid_buf

// File: bench/eti_tx_overhead_asserts.sv
/*
 * Port-level checker for the E3 transmit overhead block.
 * Assumes it is bound to the top module.
 */
`timescale 1ns/1ps
module eti_tx_overhead_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic in_valid,
    input wire eti_pkg::eti_beat_t in_beat,
    input wire logic in_ready,
    input wire logic hdlc_data,
    input wire logic hdlc_advance,
    input wire logic feac_data,
    input wire logic feac_advance,
    input wire eti_pkg::eti_alarm_t rx_alarm,
    input wire logic manual_error_insert_input,
    input wire logic line_valid,
    input wire logic line_data,
    input wire logic line_ready
);
    logic [15:0] ovh_q, err_q;
    logic [1:0] ais_cnt_q;
    logic acc, hdlc_use, feac_use, en_off;
    assign acc = in_valid && in_ready;
    assign hdlc_use = acc && in_beat.n_pos && !ovh_q[1] && ovh_q[9:8] == 2'h1;
    assign feac_use = acc && in_beat.fas && in_beat.fas_idx == 4'h0 && !ovh_q[1]
        && (ovh_q[9:8] == 2'h2 || ovh_q[3:2] == 2'h1);
    assign en_off = !err_q[2];
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ovh_q <= 16'h0000;
            err_q <= 16'h0000;
        end else if (reg_wr && reg_addr == 8'h18) begin
            ovh_q <= reg_wdata & eti_pkg::TX_OVH_CTRL_MASK;
        end else if (reg_wr && reg_addr == 8'h1a) begin
            err_q <= reg_wdata & eti_pkg::TX_ERR_CTRL_MASK;
        end
    end
    // Beats taken under all-ones; older buffered beats are skipped.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ais_cnt_q <= 2'h0;
        end else if (!ovh_q[0]) begin
            ais_cnt_q <= 2'h0;
        end else if (acc && ais_cnt_q != 2'h3) begin
            ais_cnt_q <= ais_cnt_q + 2'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_rd_ovh; reg_rd && reg_addr == 8'h18 |=> reg_rdata == ovh_q; endproperty
    property p_rd_err; reg_rd && reg_addr == 8'h1a |=> reg_rdata == err_q; endproperty
    property p_rd_unmapped;
        reg_rd && !(reg_addr inside {8'h18, 8'h1a, 8'h1c, 8'h1e}) |=> reg_rdata == 16'h0000;
    endproperty
    property p_hdlc; 1'b1 |=> hdlc_advance == $past(hdlc_use); endproperty
    property p_feac; 1'b1 |=> feac_advance == $past(feac_use); endproperty
    property p_hold; line_valid && !line_ready |=> line_valid && $stable(line_data); endproperty
    property p_ais; line_valid && ais_cnt_q == 2'h3 |-> line_data; endproperty
    property p_en_off;
        reg_rd && reg_addr == 8'h1e && en_off && $past(en_off) && $past(en_off, 2)
            |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_rd_ovh: assert property (p_rd_ovh) else $error("ovh readback wrong");
    a_rd_err: assert property (p_rd_err) else $error("err readback wrong");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    a_hdlc: assert property (p_hdlc) else $error("hdlc advance wrong");
    a_feac: assert property (p_feac) else $error("feac advance wrong");
    a_hold: assert property (p_hold) else $error("line changed in stall");
    a_ais: assert property (p_ais) else $error("line bit not one");
    a_en_off: assert property (p_en_off) else $error("pending while disabled");
    c_ais: cover property (line_valid && ais_cnt_q == 2'h3);
    c_feac: cover property (feac_advance);
    c_stall: cover property (line_valid && !line_ready ##1 line_valid && !line_ready);
endmodule : eti_tx_overhead_asserts

// File: bench/eti_line_model.sv
/*
 * Line partner: ready always, one cycle in four, or never.
 * Assumes the bench reads got at the rising edge.
 */
`timescale 1ns/1ps
module eti_line_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic line_valid,
    input wire logic line_data,
    input wire logic stall,
    input wire logic slow,
    output logic line_ready,
    output logic got,
    output logic got_bit
);
    logic [1:0] cnt_q;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 2'h0;
            line_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            line_ready <= !stall && (!slow || cnt_q == 2'h3);
        end
    end
    assign got = line_valid && line_ready;
    assign got_bit = line_data;
endmodule : eti_line_model

// File: bench/tb_eti_tx_overhead.sv
/*
 * Self-checking bench with register tasks and a framed beat stream.
 * Assumes the design, package and checker are compiled first.
 */
`timescale 1ns/1ps
module tb_eti_tx_overhead;
    logic core_clk, reset, reg_wr, reg_rd, in_valid, in_ready, hdlc_data, hdlc_advance;
    logic feac_data, feac_advance, manual_error_insert_input, line_valid, line_data;
    logic line_ready, stall, slow, got, got_bit, gen_dis, ais_on, oi_en, oi_d;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    eti_pkg::eti_beat_t in_beat;
    eti_pkg::eti_alarm_t rx_alarm;
    logic exp_q[$];
    int err_count, samples_checked;
    logic [12:0] alm_tbl [8] = '{13'h1001, 13'h1080, 13'h0801, 13'h0840,
                                 13'h0401, 13'h0420, 13'h0200, 13'h0301};

    eti_tx_overhead DUT (.*);
    eti_line_model u_line (.*);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task summarize;
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task timeout;
        err_count++;
        $display("mismatch handshake expected done seen stuck");
        summarize();
    endtask : timeout
    task wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, e);
        @(posedge core_clk);
    endtask : rd
    function eti_pkg::eti_beat_t bt(input logic d, input logic f, input logic [3:0] i,
                                    input logic a, input logic n);
        return '{d, f, i, a, n, oi_en, oi_d};
    endfunction : bt
    task put(input eti_pkg::eti_beat_t b, input logic g, input logic ov, input logic fl);
        int n;
        in_valid <= 1'b1;
        in_beat <= b;
        n = 0;
        #1;
        while (in_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 200) timeout();
        @(posedge core_clk);
        exp_q.push_back(ais_on | (((ov && oi_en) ? oi_d : ((ov && !gen_dis) ? g : b.data)) ^ fl));
    endtask : put
    task pay(input logic d);
        put(bt(d, 1'b0, 4'h5, 1'b0, 1'b0), 1'b0, 1'b0, 1'b0);
    endtask : pay
    task drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 400) timeout();
        repeat (2) @(posedge core_clk);
    endtask : drain
    task frame(input logic [9:0] fin, input logic ain, input logic nin, input logic ae,
               input logic ne, input logic [9:0] em);
        for (int i = 0; i < 10; i++) begin
            put(bt(fin[9-i], 1'b1, 4'(i), 1'b0, 1'b0), eti_pkg::FAS_PATTERN[9-i], 1'b1, em[9-i]);
        end
        put(bt(ain, 1'b0, 4'h5, 1'b1, 1'b0), ae, 1'b1, 1'b0);
        put(bt(nin, 1'b0, 4'h5, 1'b0, 1'b1), ne, 1'b1, 1'b0);
        pay(1'b1);
        pay(1'b0);
        in_valid <= 1'b0;
        drain();
    endtask : frame
    task ef(input logic [9:0] em);
        frame(10'h0a5, 1'b1, 1'b0, 1'b0, 1'b1, em);
    endtask : ef
    task pulse;
        manual_error_insert_input <= 1'b1;
        repeat (6) @(posedge core_clk);
        manual_error_insert_input <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : pulse

    always @(posedge core_clk) begin
        if (!reset && got) begin
            check("line_data", got_bit, exp_q.size() != 0 ? exp_q.pop_front() : 1'bx);
        end
    end

    initial begin
        logic ae, ne;
        {reg_wr, reg_rd, in_valid, hdlc_data, feac_data, manual_error_insert_input} = '0;
        {stall, slow, gen_dis, ais_on, oi_en, oi_d, reg_addr, reg_wdata, in_beat} = '0;
        {rx_alarm, err_count, samples_checked} = '0;
        reset = 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(8'h18, 16'h0000);
        rd(8'h1a, 16'h0000);
        rd(8'h40, 16'h0000);
        wr(8'h18, 16'hffff);
        rd(8'h18, 16'h030f);
        wr(8'h18, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            hdlc_data <= j[0];
            feac_data <= !j[0];
            for (int k = 0; k < 4; k++) begin
                wr(8'h18, {6'h00, 2'(k), 4'h0, 2'(k), 2'h0});
                ne = (k == 0) ? 1'b1 : (k == 1) ? hdlc_data : (k == 2) ? feac_data : 1'b0;
                ae = (k == 1) ? feac_data : (k == 3);
                frame(10'h0a5, !ae, !ne, ae, ne, 10'h000);
            end
        end
        feac_data <= 1'b1;
        wr(8'h18, 16'h0204);
        frame(10'h0a5, 1'b0, 1'b0, 1'b1, 1'b1, 10'h000);
        gen_dis = 1'b1;
        wr(8'h18, 16'h0002);
        frame(10'h0a5, 1'b1, 1'b0, 1'b0, 1'b0, 10'h000);
        oi_en = 1'b1;
        for (int d = 0; d < 2; d++) begin
            oi_d = d[0];
            frame({10{!oi_d}}, !oi_d, !oi_d, 1'b0, 1'b0, 10'h000);
        end
        {gen_dis, oi_en} = 2'b00;
        ais_on = 1'b1;
        wr(8'h18, 16'h0001);
        frame(10'h000, 1'b0, 1'b0, 1'b0, 1'b0, 10'h000);
        ais_on = 1'b0;
        wr(8'h18, 16'h0000);
        slow <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            wr(8'h1a, {11'h000, 2'(t), 3'h4});
            wr(8'h1a, {11'h000, 2'(t), 3'h6});
            wr(8'h1a, {11'h000, 2'(t), 3'h4});
            for (int f = 0; f < 5; f++) begin
                ef(f < (t > 1 ? 4 : 1) ? (t[0] ? 10'h3ff : 10'h200) : 10'h000);
            end
        end
        slow <= 1'b0;
        wr(8'h1a, 16'h0004);
        for (int r = 0; r < 4; r++) wr(8'h1a, r[0] ? 16'h0004 : 16'h0006);
        ef(10'h200);
        ef(10'h000);
        wr(8'h1a, 16'h001c);
        wr(8'h1a, 16'h001e);
        ef(10'h3ff);
        wr(8'h1a, 16'h001a);
        ef(10'h000);
        rd(8'h1e, 16'h0000);
        wr(8'h1a, 16'h0018);
        wr(8'h1a, 16'h001a);
        ef(10'h000);
        wr(8'h1a, 16'h0018);
        wr(8'h1a, 16'h000d);
        pulse();
        ef(10'h3ff);
        wr(8'h1a, 16'h000f);
        ef(10'h000);
        wr(8'h1a, 16'h000d);
        wr(8'h1a, 16'h000c);
        pulse();
        ef(10'h000);
        wr(8'h1a, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            rx_alarm <= alm_tbl[i][12:9];
            wr(8'h1c, {8'h00, alm_tbl[i][8:1]});
            repeat (8) @(posedge core_clk);
            frame(10'h0a5, !alm_tbl[i][0], 1'b0, alm_tbl[i][0], 1'b1, 10'h000);
        end
        rx_alarm <= '0;
        stall <= 1'b1;
        pay(1'b1);
        pay(1'b0);
        in_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("in_ready", in_ready, 1'b0);
        stall <= 1'b0;
        drain();
        summarize();
    end
endmodule : tb_eti_tx_overhead

bind eti_tx_overhead eti_tx_overhead_asserts u_chk (.*);
